// ===== rtl/arop_pkg.sv
// Constants for the converter result output port.
// Assumes a 10 MHz pclk and the APB register map below.
//
// Overview of operation
// - Outside serial mode 3, pins 10 to 13 carry result bits 10 to 13.
// - Upper pins always carry result bits 14 to 17 in every mode.
// - Serial mode 3 shifts each result out MSB first with the serial clock.
// - Output coding follows output_format_select: binary high, two's complement low.
// - Internal read clock: serial data stays valid across both clock edges.
// - External clock, normal polarity: data changes on rising edge, valid on falling.
// - External clock, inverted polarity: data changes on falling edge, valid on rising.
// - Serial clock is driven out with internal clock, taken in with external.
// - Internal clock, marker not inverted: frame marker high while data valid.
// - Internal clock, marker inverted: frame marker low while data valid.
// - Incomplete read flag exists only in external clock serial mode.
// - Unfinished external read at conversion end loses data and pulses the flag.
// - Busy rises at conversion start, falls at conversion end as the result register loads.
// - Internal clock: chain pin high reads during conversion, low only after it.
// - External clock: chain pin level appears on serial data 18 periods later.
// - Output drivers enabled only while chip select and read strobe are low.
// - Chip select gates the external serial clock.

package arop_pkg;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] RESULT_OFS = 8'h08;

    // Control field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_EXT_BIT  = 2;
    localparam int CTRL_INVS_BIT = 3;
    localparam int CTRL_INVF_BIT = 4;
    localparam int CTRL_FMT_BIT  = 5;
    localparam int CTRL_WIDTH    = 6;
    localparam logic [5:0] CTRL_RESET = 6'h20;

    // Status field positions
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_NEW_BIT  = 1;
    localparam int STAT_INT_BIT  = 2;
    localparam int STAT_ERR_BIT  = 3;
    localparam int STAT_CNT_LSB  = 8;

    // Mode code selecting the serial interface
    localparam logic [1:0] MODE_SERIAL = 2'h3;

    // Result and serial read size
    localparam int RESULT_BITS = 18;

    // Internal read clock timing
    localparam int CLK_PERIOD_NS      = 100;
    localparam int INT_SCLK_PERIOD_NS = 400;
    localparam int QTR_CYCLES_RAW     = INT_SCLK_PERIOD_NS / (4 * CLK_PERIOD_NS);
    localparam int QTR_CYCLES         = (QTR_CYCLES_RAW < 1) ? 1 : QTR_CYCLES_RAW;

    // Internal read sequence states, Gray coded
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SHIFT = 2'b01,
        ST_HOLD  = 2'b11
    } arop_state_t;

endpackage

// ===== rtl/arop_top.sv
// Result output port: parallel upper bits, serial reuse of pins 10..13, busy.
// Assumes conv_start/conv_done/conv_result come from the converter core on pclk;
// host pins are asynchronous and are synchronised here.
`timescale 1ns/100ps

module arop_top
#(
    parameter int RBITS = arop_pkg::RESULT_BITS
)
(
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic             conv_start,
    input  wire logic             conv_done,
    input  wire logic [RBITS-1:0] conv_result,
    input  wire logic             cs_n,
    input  wire logic             rd_n,
    input  wire logic             read_timing_select_or_chain_in,
    input  wire logic             par_bit_11_i,
    output logic                  par_bit_10_o,
    output logic                  par_bit_10_oe,
    output logic                  par_bit_11_o,
    output logic                  par_bit_11_oe,
    output logic                  par_bit_12_o,
    output logic                  par_bit_12_oe,
    output logic                  par_bit_13_o,
    output logic                  par_bit_13_oe,
    output logic      [3:0]       parallel_upper_bits,
    output logic                  parallel_upper_bits_oe,
    output logic                  busy
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    ////////////////////////////////////////////////////////////////////////////

    logic [arop_pkg::CTRL_WIDTH-1:0] ctrl;
    logic [RBITS-1:0]                result_q;
    logic [RBITS-1:0]                shreg;
    logic [3:0]                      sync1;
    logic [3:0]                      sync2;
    logic                            sclk_prev;
    logic                            new_data;
    logic                            err_seen;
    logic                            err_pulse;
    logic [4:0]                      bit_cnt;
    logic [4:0]                      ext_cnt;
    logic [1:0]                      qtr;
    logic [3:0]                      qtr_tick;
    logic                            int_sclk;
    arop_pkg::arop_state_t           state;

    logic        serial;
    logic        ext_clk;
    logic        inv_sclk;
    logic        inv_fm;
    logic        fmt_bin;
    logic        cs_s;
    logic        sel;
    logic        chain_s;
    logic        sclk_s;
    logic        ext_edge;
    logic        qtr_end;
    logic        bit_end;
    logic        int_start;
    logic        ext_unfinished;
    logic        apb_do;
    logic [RBITS-1:0] coded;

    ////////////////////////////////////////////////////////////////////////////
    // Control decode and pin synchronisers
    ////////////////////////////////////////////////////////////////////////////

    // Control fields
    assign serial   = (ctrl[arop_pkg::CTRL_MODE_LSB +: 2] == arop_pkg::MODE_SERIAL);
    assign ext_clk  = ctrl[arop_pkg::CTRL_EXT_BIT];
    assign inv_sclk = ctrl[arop_pkg::CTRL_INVS_BIT];
    assign inv_fm   = ctrl[arop_pkg::CTRL_INVF_BIT];
    assign fmt_bin  = ctrl[arop_pkg::CTRL_FMT_BIT];

    // Two-flop synchronisers: cs_n, rd_n, chain pin, serial clock in
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1 <= 4'h3;
            sync2 <= 4'h3;
        end
        else
        begin
            sync1 <= {par_bit_11_i, read_timing_select_or_chain_in, rd_n, cs_n};
            sync2 <= sync1;
        end
    end

    // Synchronised levels
    assign cs_s    = sync2[0];
    assign sel     = !sync2[0] && !sync2[1];
    assign chain_s = sync2[2];
    assign sclk_s  = sync2[3];

    ////////////////////////////////////////////////////////////////////////////
    // Conversion result capture and busy
    ////////////////////////////////////////////////////////////////////////////

    // Coding: binary keeps the word, two's complement flips the MSB
    assign coded = fmt_bin ? conv_result : {~conv_result[RBITS-1], conv_result[RBITS-2:0]};

    // Latest result
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            result_q <= '0;
        else if (conv_done)
            result_q <= coded;
    end

    // Busy from conversion start until conversion end, when result_q loads
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            busy <= 1'b0;
        else if (conv_start)
            busy <= 1'b1;
        else if (conv_done)
            busy <= 1'b0;
    end

    // Unread result flag for internal-clock reads
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            new_data <= 1'b0;
        else if (conv_done)
            new_data <= 1'b1;
        else if (int_start)
            new_data <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Internal read clock sequence
    ////////////////////////////////////////////////////////////////////////////

    // Read starts on select; chain pin high allows reading during conversion
    assign int_start = serial && !ext_clk && sel && new_data && (state == arop_pkg::ST_IDLE)
                       && (chain_s || !busy);
    assign qtr_end   = (qtr_tick == 4'(arop_pkg::QTR_CYCLES - 1));
    assign bit_end   = qtr_end && (qtr == 2'h3);

    // Read state machine
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state <= arop_pkg::ST_IDLE;
        else
        begin
            unique case (state)
                arop_pkg::ST_IDLE:
                    if (int_start)
                        state <= arop_pkg::ST_SHIFT;
                arop_pkg::ST_SHIFT:
                    if (bit_end && bit_cnt == 5'(RBITS - 1))
                        state <= arop_pkg::ST_HOLD;
                arop_pkg::ST_HOLD:
                    if (!sel)
                        state <= arop_pkg::ST_IDLE;
                default:
                    state <= arop_pkg::ST_IDLE;
            endcase
        end
    end

    // Quarter-period timer and bit counter
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            qtr_tick <= 4'h0;
            qtr      <= 2'h0;
            bit_cnt  <= 5'h00;
        end
        else if (state != arop_pkg::ST_SHIFT)
        begin
            qtr_tick <= 4'h0;
            qtr      <= 2'h0;
            bit_cnt  <= 5'h00;
        end
        else
        begin
            qtr_tick <= qtr_end ? 4'h0 : qtr_tick + 4'h1;
            if (qtr_end)
                qtr <= qtr + 2'h1;
            if (bit_end)
                bit_cnt <= bit_cnt + 5'h01;
        end
    end

    // Clock high in quarters 1 and 2; data moves only at the end of quarter 3
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            int_sclk <= 1'b0;
        else
            int_sclk <= (state == arop_pkg::ST_SHIFT) && qtr_end && (qtr == 2'h0 || qtr == 2'h1);
    end

    ////////////////////////////////////////////////////////////////////////////
    // External clock detection and error flag
    ////////////////////////////////////////////////////////////////////////////

    // Previous clock level, updated every cycle, also while deselected
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sclk_prev <= 1'b0;
        else
            sclk_prev <= sclk_s;
    end

    // Active edge per polarity, gated by chip select
    assign ext_edge = serial && ext_clk && !cs_s
                      && (inv_sclk ? (sclk_prev && !sclk_s)
                                   : (!sclk_prev && sclk_s));
    assign ext_unfinished = (ext_cnt != 5'h00) && (ext_cnt < 5'(RBITS));

    // Edges counted since last load, saturating
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ext_cnt <= 5'h00;
        else if (conv_done)
            ext_cnt <= 5'h00;
        else if (ext_edge && ext_cnt != 5'h1F)
            ext_cnt <= ext_cnt + 5'h01;
    end

    // One-cycle error pulse when a read is cut by a new result
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            err_pulse <= 1'b0;
        else
            err_pulse <= conv_done && serial && ext_clk && ext_unfinished;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output shift register
    ////////////////////////////////////////////////////////////////////////////

    // External: load at conversion end; internal: load at read start
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            shreg <= '0;
        else if (conv_done && ext_clk)
            shreg <= coded;
        else if (int_start)
            shreg <= result_q;
        else if (ext_edge)
            shreg <= {shreg[RBITS-2:0], chain_s};
        else if (bit_end && state == arop_pkg::ST_SHIFT)
            shreg <= {shreg[RBITS-2:0], 1'b0};
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drivers
    ////////////////////////////////////////////////////////////////////////////

    // Pins 10..13 data
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            par_bit_10_o <= 1'b0;
            par_bit_11_o <= 1'b0;
            par_bit_12_o <= 1'b0;
            par_bit_13_o <= 1'b0;
        end
        else if (!serial)
        begin
            par_bit_10_o <= result_q[10];
            par_bit_11_o <= result_q[11];
            par_bit_12_o <= result_q[12];
            par_bit_13_o <= result_q[13];
        end
        else
        begin
            par_bit_10_o <= shreg[RBITS-1];
            par_bit_11_o <= int_sclk;
            if (ext_clk)
                par_bit_12_o <= inv_fm;
            else
                par_bit_12_o <= (state == arop_pkg::ST_SHIFT) ^ inv_fm;
            par_bit_13_o <= ext_clk && err_pulse;
        end
    end

    // Output enables follow chip select and read strobe; pin 11 stays disabled in external-clock serial mode
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            par_bit_10_oe          <= 1'b0;
            par_bit_11_oe          <= 1'b0;
            par_bit_12_oe          <= 1'b0;
            par_bit_13_oe          <= 1'b0;
            parallel_upper_bits_oe <= 1'b0;
        end
        else
        begin
            par_bit_10_oe          <= sel;
            par_bit_11_oe          <= sel && !(serial && ext_clk);
            par_bit_12_oe          <= sel;
            par_bit_13_oe          <= sel;
            parallel_upper_bits_oe <= sel;
        end
    end

    // Upper bits in every mode
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            parallel_upper_bits <= 4'h0;
        else
            parallel_upper_bits <= result_q[17:14];
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB slave: one wait state, pready from a flop
    ////////////////////////////////////////////////////////////////////////////

    assign apb_do = psel && penable && pready;

    // Answer one cycle into the access phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= psel && penable && !pready;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (psel && penable && !pready)
            begin
                unique case (paddr)
                    arop_pkg::CTRL_OFS:
                        prdata <= 32'(ctrl);
                    arop_pkg::STATUS_OFS:
                    begin
                        prdata[arop_pkg::STAT_BUSY_BIT]   <= busy;
                        prdata[arop_pkg::STAT_NEW_BIT]    <= new_data;
                        prdata[arop_pkg::STAT_INT_BIT]    <= (state != arop_pkg::ST_IDLE);
                        prdata[arop_pkg::STAT_ERR_BIT]    <= err_seen;
                        prdata[arop_pkg::STAT_CNT_LSB +: 5] <= ext_clk ? ext_cnt : bit_cnt;
                    end
                    arop_pkg::RESULT_OFS:
                        prdata <= 32'(result_q);
                    default:
                        pslverr <= 1'b1;
                endcase
            end
        end
    end

    // Control register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl <= arop_pkg::CTRL_RESET;
        else if (apb_do && pwrite && paddr == arop_pkg::CTRL_OFS)
            ctrl <= pwdata[arop_pkg::CTRL_WIDTH-1:0];
    end

    // Sticky error seen; a new error wins over a write-one clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            err_seen <= 1'b0;
        else if (err_pulse)
            err_seen <= 1'b1;
        else if (apb_do && pwrite && paddr == arop_pkg::STATUS_OFS && pwdata[arop_pkg::STAT_ERR_BIT])
            err_seen <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    ////////////////////////////////////////////////////////////////////////////

    AST_BUSY_RISE: assert property (@(posedge pclk) disable iff (!presetn)
        conv_start |=> busy ##0 busy[*1])
        else $error("busy did not rise after conversion start");

    AST_BUSY_FALL: assert property (@(posedge pclk) disable iff (!presetn)
        (conv_done && !conv_start && ext_clk) |=> (!busy && shreg == $past(coded)))
        else $error("busy fell without the result in the shifter");

    AST_PAR_BITS: assert property (@(posedge pclk) disable iff (!presetn)
        (!serial && !conv_done) ##1 !serial |=> par_bit_10_o == $past(result_q[10], 2))
        else $error("parallel bit 10 does not carry the result");

    AST_OE_GATE: assert property (@(posedge pclk) disable iff (!presetn)
        !sel |=> (!par_bit_10_oe && !parallel_upper_bits_oe && !par_bit_12_oe))
        else $error("driver enabled without chip select and read");

    AST_FORMAT: assert property (@(posedge pclk) disable iff (!presetn)
        (conv_done && !fmt_bin) |=> result_q[RBITS-1] == !$past(conv_result[RBITS-1]))
        else $error("two's complement coding not applied");

    AST_EXT_MARKER: assert property (@(posedge pclk) disable iff (!presetn)
        (serial && ext_clk) ##1 (serial && ext_clk && $stable(inv_fm)) |-> par_bit_12_o == inv_fm)
        else $error("frame marker active with external clock");

    AST_ERR_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
        (conv_done && serial && ext_clk && ext_unfinished) |=> err_pulse ##1 !err_pulse)
        else $error("incomplete read not flagged by one pulse");

    AST_INT_STABLE: assert property (@(posedge pclk) disable iff (!presetn)
        (state == arop_pkg::ST_SHIFT && int_sclk) |-> $stable(shreg[RBITS-1]))
        else $error("serial data moved while internal clock high");

    AST_INT_FRAME: assert property (@(posedge pclk) disable iff (!presetn)
        (serial && !ext_clk && !inv_fm && state == arop_pkg::ST_SHIFT) ##1 (serial && !ext_clk && !inv_fm)
        |-> par_bit_12_o)
        else $error("frame marker not high during read");

    AST_READ_LEN: assert property (@(posedge pclk) disable iff (!presetn)
        (state == arop_pkg::ST_SHIFT && bit_end && bit_cnt == 5'(RBITS - 1)) |=> state == arop_pkg::ST_HOLD)
        else $error("internal read did not end after eighteen bits");

    AST_CLK_GATE: assert property (@(posedge pclk) disable iff (!presetn)
        cs_s |-> !ext_edge)
        else $error("external clock edge taken while deselected");

    AST_CHAIN: assert property (@(posedge pclk) disable iff (!presetn)
        (ext_edge && !conv_done && !int_start) |=> shreg[0] == $past(chain_s))
        else $error("chain input not shifted in");

endmodule // arop_top

// ===== test/arop_host.sv
// Host model: select, read strobe and external serial clock.
// Assumes pclk at 10 MHz; link clock 800 ns, still between frames.
`timescale 1ns/100ps

module arop_host
(
    input  wire logic pclk,
    input  wire logic sdo,
    output logic      sclk,
    output logic      cs_n,
    output logic      rd_n
);
    logic [18:0] word;

    // Idle levels at time zero
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        rd_n = 1'b1;
    end

    // Select and read strobe move together
    task automatic sel(input logic v);
        cs_n <= v;
        rd_n <= v;
    endtask

    // Sample a bit, then give the active edge
    task automatic xfer(input int n, input logic inv);
        word = '0;
        sclk <= inv;
        repeat (4) @(posedge pclk);
        sel(1'b0);
        repeat (8) @(posedge pclk);
        for (int i = 0; i < n; i++)
        begin
            word = {word[17:0], sdo};
            sclk <= ~inv;
            repeat (4) @(posedge pclk);
            sclk <= inv;
            repeat (4) @(posedge pclk);
        end
        word = {word[17:0], sdo};
    endtask
endmodule // arop_host

// ===== test/test_adc_result_output_port.sv
// Bench: APB, parallel pins, serial reads on both clock sources.
// Assumes arop_host at the serial pins; pclk 10 MHz.
`timescale 1ns/100ps

module test_adc_result_output_port;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        conv_start = 1'b0;
    logic        conv_done = 1'b0;
    logic [17:0] conv_result = 18'h0;
    logic        chain_in = 1'b0;
    logic [31:0] prdata;
    logic        pready, pslverr, busy, upper_oe, sclk, cs_n, rd_n;
    logic [3:0]  upper, pin_o, pin_oe;
    logic [17:0] r;
    int          failures = 0;
    int          cmp_count = 0;
    int          err_cnt = 0;
    int          e0;
    int          seed = 32'h164C;

    arop_top uut
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .conv_start(conv_start),
        .conv_done(conv_done), .conv_result(conv_result), .cs_n(cs_n), .rd_n(rd_n),
        .read_timing_select_or_chain_in(chain_in), .par_bit_11_i(sclk),
        .par_bit_10_o(pin_o[0]), .par_bit_10_oe(pin_oe[0]),
        .par_bit_11_o(pin_o[1]), .par_bit_11_oe(pin_oe[1]),
        .par_bit_12_o(pin_o[2]), .par_bit_12_oe(pin_oe[2]),
        .par_bit_13_o(pin_o[3]), .par_bit_13_oe(pin_oe[3]),
        .parallel_upper_bits(upper), .parallel_upper_bits_oe(upper_oe), .busy(busy)
    );

    arop_host host (.pclk(pclk), .sdo(pin_o[0]), .sclk(sclk), .cs_n(cs_n), .rd_n(rd_n));

    always #50 pclk = ~pclk;

    // Counts cycles with the incomplete-read flag up
    always @(posedge pclk)
        if (pin_o[3] === 1'b1) err_cnt++;

    function automatic logic [17:0] code(input logic [17:0] v, input logic bin);
        return bin ? v : {~v[17], v[16:0]};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        if (failures == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // One APB transfer, read data masked and compared
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] x, input logic [31:0] m, input logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        chk(prdata & m, x);
        chk(pslverr, e);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Conversion pulses, busy checked around them
    task automatic conv(input logic [17:0] v);
        conv_start <= 1'b1;
        @(posedge pclk);
        conv_start <= 1'b0;
        conv_result <= v;
        repeat (2) @(posedge pclk);
        chk(busy, 1'b1);
        conv_done <= 1'b1;
        @(posedge pclk);
        conv_done <= 1'b0;
        repeat (2) @(posedge pclk);
        chk(busy, 1'b0);
    endtask

    // Internal clock read, bits taken on both clock edges
    task automatic intrd(input logic invf, input logic [17:0] x, input int nact);
        logic [17:0] wa, wb;
        logic        p;
        int          act;
        wa = 18'h0;
        wb = 18'h0;
        p = 1'b0;
        act = 0;
        host.sel(1'b0);
        repeat (150)
        begin
            @(posedge pclk);
            if (pin_o[2] === ~invf)
            begin
                act++;
                if (pin_o[1] === 1'b1 && p === 1'b0) wa = {wa[16:0], pin_o[0]};
                if (pin_o[1] === 1'b0 && p === 1'b1) wb = {wb[16:0], pin_o[0]};
            end
            p = pin_o[1];
        end
        host.sel(1'b1);
        repeat (4) @(posedge pclk);
        chk(wa, x);
        chk(wb, x);
        chk(act, nact);
    endtask

    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({busy, upper_oe, pin_oe}, 6'h00);
        apb(1'b0, arop_pkg::CTRL_OFS, 32'h0, 32'h20, 32'hFFFFFFFF, 1'b0);
        apb(1'b0, 8'h10, 32'h0, 32'h0, 32'hFFFFFFFF, 1'b1);
        apb(1'($random(seed)), 8'h0C | {4'($random(seed)), 4'h0}, $random(seed), 32'h0, 32'hFFFFFFFF, 1'b1);
        // Parallel mode: corner and random results, both codings
        for (int i = 0; i < 4; i++)
        begin
            r = (i == 0) ? 18'h00000 : (i == 1) ? 18'h3FFFF : 18'($random(seed));
            apb(1'b1, arop_pkg::CTRL_OFS, {26'($random(seed)), i[0], 5'h00}, 32'h0, 32'h0, 1'b0);
            conv(r);
            host.sel(1'b0);
            repeat (4) @(posedge pclk);
            chk({upper, pin_o}, code(r, i[0]) >> 10);
            chk({upper_oe, pin_oe}, 5'h1F);
            apb(1'b0, arop_pkg::RESULT_OFS, 32'h0, code(r, i[0]), 32'h3FFFF, 1'b0);
            host.sel(1'b1);
            repeat (4) @(posedge pclk);
            chk({upper_oe, pin_oe}, 5'h00);
        end
        apb(1'b1, arop_pkg::RESULT_OFS, 32'h0, 32'h0, 32'h0, 1'b0);
        apb(1'b0, arop_pkg::RESULT_OFS, 32'h0, r, 32'h3FFFF, 1'b0);
        // Internal read clock, both marker polarities; chain pin decides read during conversion
        for (int v = 0; v < 2; v++)
        begin
            r = 18'($random(seed));
            chain_in <= v[0];
            apb(1'b1, arop_pkg::CTRL_OFS, {26'h0, 1'b1, v[0], 4'h3}, 32'h0, 32'h0, 1'b0);
            conv(r);
            conv_start <= 1'b1;
            @(posedge pclk);
            conv_start <= 1'b0;
            intrd(v[0], v[0] ? r : 18'h0, v[0] ? 72 : 0);
            chk(busy, 1'b1);
            conv_done <= 1'b1;
            @(posedge pclk);
            conv_done <= 1'b0;
            intrd(v[0], r, 72);
            intrd(v[0], 18'h0, 0);
        end
        // External clock, both clock polarities, chain level after data
        for (int v = 0; v < 2; v++)
        begin
            r = 18'($random(seed));
            chain_in <= 1'($random(seed));
            apb(1'b1, arop_pkg::CTRL_OFS, {26'h0, 2'b10, v[0], 3'b111}, 32'h0, 32'h0, 1'b0);
            conv(r);
            host.xfer(18, v[0]);
            chk(host.word, {r, chain_in});
            chk({pin_oe[1], pin_o[2], pin_oe[0], upper}, {3'b001, r[17:14]});
            host.sel(1'b1);
        end
        // Read cut short by the next conversion
        conv(18'($random(seed)));
        host.xfer(5, 1'b1);
        e0 = err_cnt;
        r = 18'($random(seed));
        conv(r);
        repeat (4) @(posedge pclk);
        chk(err_cnt, e0 + 1);
        apb(1'b0, arop_pkg::STATUS_OFS, 32'h0, 32'h8, 32'h8, 1'b0);
        host.sel(1'b1);
        host.xfer(18, 1'b1);
        chk(host.word[18:1], r);
        host.sel(1'b1);
        chk(err_cnt, e0 + 1);
        summarize();
    end

    // Watchdog
    initial
    begin
        #3000000;
        failures++;
        summarize();
    end
endmodule // test_adc_result_output_port
